// ===== design/slc_device.sv
// link control register bank with timestamp-on-lsb datapath, sync request and multiframe counter
// assumes registers are written through slc_link_if and that sample input is two's complement
`timescale 1ns/1ps
// Overview of operation
// - timestamp enable puts timestamp on sample lsb
// - timestamp delayed equal to sample latency
// - host sets sync receiver with timestamp
// - lsb replaces data bit, 8 or 12
// - ila control bits per sample is zero
// - link enable bit, resets to one
// - disabled link held reset, powered down, gated
// - multiframe counter held reset while disabled
// - host clears link enable before reconfiguring
// - calibration on before link, off after
// - link mode register, reset 0x02
// - mode changes only with link, calibration off
// - only mask-allowed link modes accepted
// - multiframe length is frames minus one
// - 64b/66b modes use 256*E/F frames
// - soft sync zero requests synchronization
// - soft sync works for any source
// - link control layout, reset 0x03
// - sync source: pin, timestamp, software only
// - format bit: offset binary or two's complement
module slc_device
  import slc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  slc_link_if.dev bus,
  input wire logic [SAMPLE_W-1:0] sampleIn,
  input wire logic sampleInValid,
  input wire logic timestampPin,
  input wire logic syncPin_n,
  input wire logic sysrefPin,
  input wire logic frameTick,
  output logic [SAMPLE_W-1:0] sampleOut,
  output logic sampleOutValid,
  output logic linkReset,
  output logic serializerPowerDown,
  output logic linkClockEnable,
  output logic syncRequest,
  output logic scramblerOn,
  output logic upperLaneMap,
  output logic lmfcBoundary,
  output logic [1:0] ilaControlBits,
  output logic calibrationEnable,
  output logic syncReceiverEnable
);
  logic [DATA_W-1:0] lsbCtrl_reg;
  logic [DATA_W-1:0] linkEn_reg;
  logic [DATA_W-1:0] linkMode_reg;
  logic [DATA_W-1:0] mfLen_reg;
  logic [DATA_W-1:0] softSync_reg;
  logic [DATA_W-1:0] linkCtrl_reg;
  logic [DATA_W-1:0] calCtrl_reg;
  logic [DATA_W-1:0] modeMask_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [2:0] pinS1_reg;
  logic [2:0] pinS2_reg;
  logic [2:0] pinS3_reg;
  logic [2:0] pinFilt_reg;
  logic [2:0] pinFilt_next;
  logic sysrefPrev_reg;
  logic [SAMPLE_W-1:0] samplePipe_reg [PIPE_DEPTH];
  logic [PIPE_DEPTH-1:0] validPipe_reg;
  logic [DATA_W-1:0] mfCount_reg;
  logic [DATA_W-1:0] kMinusOne;
  logic linkOn;
  logic is64b;
  logic is8bit;
  logic tsLevel;
  logic modeAllowed;
  logic syncReqNext;
  logic [SAMPLE_W-1:0] conv;
  logic [SAMPLE_W-1:0] shaped;
  slc_sync_sel_type syncSel;

  assign linkOn = linkEn_reg[BIT_LINK_EN];
  assign is64b = linkMode_reg[MODE_64B_BIT];
  assign is8bit = linkMode_reg[MODE_8BIT_BIT];
  assign syncSel = slc_sync_sel_type'(linkCtrl_reg[SYNC_SEL_LO +: 2]);
  // timestamp pin only counts when its receiver is on
  assign tsLevel = pinFilt_reg[PIN_TS] & calCtrl_reg[BIT_SYNC_RECV];
  assign modeAllowed = (bus.regWdata < DATA_W'(MODE_COUNT)) &&
                       modeMask_reg[bus.regWdata[2:0]];
  assign kMinusOne = is64b ? slc_k_minus_one_64b(linkMode_reg) : mfLen_reg;

  // register writes keep every bit, reserved ones included
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lsbCtrl_reg <= RST_LSB_CTRL;
      linkEn_reg <= RST_LINK_EN;
      linkMode_reg <= RST_LINK_MODE;
      mfLen_reg <= RST_MF_LEN;
      softSync_reg <= RST_SOFT_SYNC;
      linkCtrl_reg <= RST_LINK_CTRL;
      calCtrl_reg <= RST_CAL_CTRL;
      modeMask_reg <= RST_MODE_MASK;
    end else if (ce && bus.regWrite) begin
      unique case (bus.regAddr)
        ADDR_LSB_CTRL: lsbCtrl_reg <= bus.regWdata;
        ADDR_LINK_EN: linkEn_reg <= bus.regWdata;
        ADDR_LINK_MODE: begin
          if (modeAllowed) begin
            linkMode_reg <= bus.regWdata;
          end
        end
        ADDR_MF_LEN: mfLen_reg <= bus.regWdata;
        ADDR_SOFT_SYNC: softSync_reg <= bus.regWdata;
        ADDR_LINK_CTRL: linkCtrl_reg <= bus.regWdata;
        ADDR_CAL_CTRL: calCtrl_reg <= bus.regWdata;
        ADDR_MODE_MASK: modeMask_reg <= bus.regWdata;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rdata_next = '0;
    if (bus.regRead) begin
      unique case (bus.regAddr)
        ADDR_LSB_CTRL: rdata_next = lsbCtrl_reg;
        ADDR_LINK_EN: rdata_next = linkEn_reg;
        ADDR_LINK_MODE: rdata_next = linkMode_reg;
        ADDR_MF_LEN: rdata_next = mfLen_reg;
        ADDR_SOFT_SYNC: rdata_next = softSync_reg;
        ADDR_LINK_CTRL: rdata_next = linkCtrl_reg;
        ADDR_CAL_CTRL: rdata_next = calCtrl_reg;
        ADDR_MODE_MASK: rdata_next = modeMask_reg;
        ADDR_LINK_STATUS: begin
          rdata_next[BIT_ST_SYNC_REQ] = syncRequest;
          rdata_next[BIT_ST_LINK_RST] = linkReset;
        end
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_reg <= '0;
    end else if (ce) begin
      rdata_reg <= rdata_next;
    end
  end
  assign bus.regRdata = rdata_reg;

  // pin inputs: three flops, a change counts once stages two and three agree
  assign pinFilt_next = (~(pinS2_reg ^ pinS3_reg) & pinS3_reg) |
                        ((pinS2_reg ^ pinS3_reg) & pinFilt_reg);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pinS1_reg <= 3'h6;
      pinS2_reg <= 3'h6;
      pinS3_reg <= 3'h6;
      pinFilt_reg <= 3'h6;
      sysrefPrev_reg <= 1'b1;
    end else if (ce) begin
      pinS1_reg <= {sysrefPin, syncPin_n, timestampPin};
      pinS2_reg <= pinS1_reg;
      pinS3_reg <= pinS2_reg;
      pinFilt_reg <= pinFilt_next;
      sysrefPrev_reg <= pinFilt_reg[PIN_SYSREF];
    end
  end

  // samples wait as many cycles as the timestamp spends in its synchroniser
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        samplePipe_reg[i] <= '0;
      end
      validPipe_reg <= '0;
    end else if (ce) begin
      samplePipe_reg[0] <= sampleIn;
      validPipe_reg <= {validPipe_reg[PIPE_DEPTH-2:0], sampleInValid & linkOn};
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        samplePipe_reg[i] <= samplePipe_reg[i-1];
      end
    end
  end

  always_comb begin
    conv = samplePipe_reg[PIPE_DEPTH-1];
    if (!linkCtrl_reg[BIT_FMT]) begin
      conv[SAMPLE_W-1] = ~conv[SAMPLE_W-1];
    end
    shaped = conv;
    if (is8bit) begin
      shaped = {(SAMPLE_W-NARROW_W)'(0), conv[SAMPLE_W-1 -: NARROW_W]};
    end
    if (lsbCtrl_reg[BIT_TS_EN]) begin
      shaped[0] = tsLevel;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sampleOut <= '0;
      sampleOutValid <= 1'b0;
    end else if (ce) begin
      sampleOut <= shaped;
      sampleOutValid <= validPipe_reg[PIPE_DEPTH-1] & linkOn;
    end
  end

  // sync pin is active low; a stuck pin is escaped by selecting any source other than the dedicated pin
  always_comb begin
    syncReqNext = ~softSync_reg[BIT_SOFT_SYNC];
    unique case (syncSel)
      SYNC_DEDICATED: syncReqNext = syncReqNext | ~pinFilt_reg[PIN_SYNC];
      SYNC_TIMESTAMP: syncReqNext = syncReqNext | ~tsLevel;
      SYNC_SOFT_ONLY: syncReqNext = syncReqNext;
      SYNC_RESERVED: syncReqNext = syncReqNext;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      linkReset <= 1'b0;
      serializerPowerDown <= 1'b0;
      linkClockEnable <= 1'b1;
      syncRequest <= 1'b0;
      scramblerOn <= 1'b1;
      upperLaneMap <= 1'b0;
      ilaControlBits <= ILA_CS_VALUE;
      calibrationEnable <= 1'b0;
      syncReceiverEnable <= 1'b0;
    end else if (ce) begin
      linkReset <= ~linkOn;
      serializerPowerDown <= ~linkOn;
      linkClockEnable <= linkOn;
      syncRequest <= syncReqNext & linkOn;
      // 64b/66b always scrambles
      scramblerOn <= linkCtrl_reg[BIT_SCR] | is64b;
      upperLaneMap <= linkCtrl_reg[BIT_LANE_MAP];
      ilaControlBits <= ILA_CS_VALUE;
      calibrationEnable <= calCtrl_reg[BIT_CAL_EN];
      syncReceiverEnable <= calCtrl_reg[BIT_SYNC_RECV];
    end
  end

  // multiframe counter; sysref rising edge realigns it only while the link runs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mfCount_reg <= '0;
      lmfcBoundary <= 1'b0;
    end else if (ce) begin
      lmfcBoundary <= 1'b0;
      if (!linkOn) begin
        mfCount_reg <= '0;
      end else if (pinFilt_reg[PIN_SYSREF] && !sysrefPrev_reg) begin
        mfCount_reg <= '0;
      end else if (frameTick) begin
        if (mfCount_reg >= kMinusOne) begin
          mfCount_reg <= '0;
          lmfcBoundary <= 1'b1;
        end else begin
          mfCount_reg <= mfCount_reg + 8'h01;
        end
      end
    end
  end
endmodule

// ===== design/slc_pkg.sv
// constants, field layout and mode table shared by both ends of the serial link control bank
// assumes a single configuration clock domain on both ends
package slc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int SAMPLE_W = 12;
  localparam int NARROW_W = 8;
  localparam int SYNC_STAGES = 3;
  localparam int PIPE_DEPTH = SYNC_STAGES + 1;
  localparam int MODE_COUNT = 8;
  localparam int MB_BLOCKS = 256;
  localparam int EXT_E = 1;

  localparam logic [ADDR_W-1:0] ADDR_LSB_CTRL = 12'h160;
  localparam logic [ADDR_W-1:0] ADDR_LINK_EN = 12'h200;
  localparam logic [ADDR_W-1:0] ADDR_LINK_MODE = 12'h201;
  localparam logic [ADDR_W-1:0] ADDR_MF_LEN = 12'h202;
  localparam logic [ADDR_W-1:0] ADDR_SOFT_SYNC = 12'h203;
  localparam logic [ADDR_W-1:0] ADDR_LINK_CTRL = 12'h204;
  localparam logic [ADDR_W-1:0] ADDR_CAL_CTRL = 12'h300;
  localparam logic [ADDR_W-1:0] ADDR_LINK_STATUS = 12'h301;
  localparam logic [ADDR_W-1:0] ADDR_MODE_MASK = 12'h302;
  localparam logic [ADDR_W-1:0] ADDR_HOST_STATUS = 12'hff0;
  localparam logic [ADDR_W-1:0] ADDR_HOST_READBACK = 12'hff1;

  localparam logic [DATA_W-1:0] RST_LSB_CTRL = 8'h00;
  localparam logic [DATA_W-1:0] RST_LINK_EN = 8'h01;
  localparam logic [DATA_W-1:0] RST_LINK_MODE = 8'h02;
  localparam logic [DATA_W-1:0] RST_MF_LEN = 8'h1f;
  localparam logic [DATA_W-1:0] RST_SOFT_SYNC = 8'h01;
  localparam logic [DATA_W-1:0] RST_LINK_CTRL = 8'h03;
  localparam logic [DATA_W-1:0] RST_CAL_CTRL = 8'h00;
  localparam logic [DATA_W-1:0] RST_MODE_MASK = 8'hff;

  localparam int BIT_TS_EN = 0;
  localparam int BIT_LINK_EN = 0;
  localparam int BIT_SOFT_SYNC = 0;
  localparam int BIT_SCR = 0;
  localparam int BIT_FMT = 1;
  localparam int SYNC_SEL_LO = 2;
  localparam int BIT_LANE_MAP = 4;
  localparam int BIT_CAL_EN = 0;
  localparam int BIT_SYNC_RECV = 1;
  localparam int BIT_ST_SYNC_REQ = 0;
  localparam int BIT_ST_LINK_RST = 1;
  localparam int BIT_HOST_BUSY = 0;
  localparam int MODE_8BIT_BIT = 0;
  localparam int MODE_64B_BIT = 2;

  localparam int PIN_TS = 0;
  localparam int PIN_SYNC = 1;
  localparam int PIN_SYSREF = 2;

  localparam logic [1:0] ILA_CS_VALUE = 2'h0;

  typedef enum logic [1:0] {
    SYNC_DEDICATED = 2'b00,
    SYNC_TIMESTAMP = 2'b01,
    SYNC_SOFT_ONLY = 2'b10,
    SYNC_RESERVED = 2'b11
  } slc_sync_sel_type;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_LINK_OFF = 2'b01,
    HOST_CAL_WRITE = 2'b10,
    HOST_MAIN = 2'b11
  } slc_host_state_type;

  // frames per multiframe minus one for 64b/66b modes: 256*E/F, F taken from the mode
  function automatic logic [7:0] slc_k_minus_one_64b(input logic [7:0] mode);
    logic [8:0] k;
    k = 9'(MB_BLOCKS * EXT_E) >> mode[1:0];
    return 8'(k - 9'h001);
  endfunction
endpackage

// ===== design/slc_link_if.sv
// register access path between the configuring end and the link control bank
// assumes both ends run on the same clk_sys; read data stand one cycle after the read strobe
`timescale 1ns/1ps
interface slc_link_if;
  import slc_pkg::*;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [DATA_W-1:0] regRdata;

  modport dev (
    input regAddr,
    input regWdata,
    input regWrite,
    input regRead,
    output regRdata
  );

  modport host (
    output regAddr,
    output regWdata,
    output regWrite,
    output regRead,
    input regRdata
  );
endinterface

// ===== design/slc_host.sv
// configuring end: takes user register writes and orders the device writes around them
// assumes it is the only writer of the device registers, so its shadow copies stay true
`timescale 1ns/1ps
module slc_host
  import slc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  slc_link_if.host bus,
  input wire logic [ADDR_W-1:0] cmdAddr,
  input wire logic [DATA_W-1:0] cmdWdata,
  input wire logic cmdWrite,
  input wire logic cmdRead,
  output logic [DATA_W-1:0] cmdRdata
);
  slc_host_state_type state_reg;
  logic [ADDR_W-1:0] pendAddr_reg;
  logic [DATA_W-1:0] pendData_reg;
  logic [DATA_W-1:0] pendCal_reg;
  logic needCal_reg;
  logic [DATA_W-1:0] linkEn_reg;
  logic [DATA_W-1:0] calCtrl_reg;
  logic [DATA_W-1:0] readback_reg;
  logic readPending_reg;
  logic [ADDR_W-1:0] devAddr_reg;
  logic [DATA_W-1:0] devWdata_reg;
  logic devWrite_reg;
  logic devRead_reg;
  logic isLinkCfg;
  logic needOff;
  logic needCalW;
  logic [DATA_W-1:0] calWant;

  // the sync request is a run-time control, so writing it leaves the link up
  assign isLinkCfg = (cmdAddr >= ADDR_LINK_MODE) && (cmdAddr <= ADDR_LINK_CTRL) &&
                     (cmdAddr != ADDR_SOFT_SYNC);

  // work out which preparatory writes the user write needs
  always_comb begin
    calWant = calCtrl_reg;
    needOff = 1'b0;
    if (linkEn_reg[BIT_LINK_EN]) begin
      needOff = isLinkCfg;
      if (cmdAddr == ADDR_CAL_CTRL && !cmdWdata[BIT_CAL_EN]) begin
        needOff = 1'b1;
      end
    end
    if (cmdAddr == ADDR_LINK_MODE) begin
      calWant[BIT_CAL_EN] = 1'b0;
    end
    if (cmdAddr == ADDR_LINK_EN && cmdWdata[BIT_LINK_EN]) begin
      calWant[BIT_CAL_EN] = 1'b1;
    end
    if (cmdAddr == ADDR_LSB_CTRL && cmdWdata[BIT_TS_EN]) begin
      calWant[BIT_SYNC_RECV] = 1'b1;
    end
    needCalW = (calWant != calCtrl_reg);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= HOST_IDLE;
      pendAddr_reg <= '0;
      pendData_reg <= '0;
      pendCal_reg <= RST_CAL_CTRL;
      needCal_reg <= 1'b0;
      linkEn_reg <= RST_LINK_EN;
      calCtrl_reg <= RST_CAL_CTRL;
      devAddr_reg <= '0;
      devWdata_reg <= '0;
      devWrite_reg <= 1'b0;
    end else if (ce) begin
      devWrite_reg <= 1'b0;
      unique case (state_reg)
        HOST_IDLE: begin
          // writes that arrive while a sequence runs are dropped
          if (cmdWrite) begin
            pendAddr_reg <= cmdAddr;
            pendData_reg <= cmdWdata;
            pendCal_reg <= calWant;
            needCal_reg <= needCalW;
            if (needOff) begin
              state_reg <= HOST_LINK_OFF;
            end else if (needCalW) begin
              state_reg <= HOST_CAL_WRITE;
            end else begin
              state_reg <= HOST_MAIN;
            end
          end else if (cmdRead && cmdAddr != ADDR_HOST_STATUS &&
                       cmdAddr != ADDR_HOST_READBACK) begin
            // reads share the pending address; a write in the same cycle wins
            pendAddr_reg <= cmdAddr;
          end
        end
        HOST_LINK_OFF: begin
          devAddr_reg <= ADDR_LINK_EN;
          devWdata_reg <= linkEn_reg & ~(DATA_W'(1) << BIT_LINK_EN);
          devWrite_reg <= 1'b1;
          linkEn_reg[BIT_LINK_EN] <= 1'b0;
          state_reg <= needCal_reg ? HOST_CAL_WRITE : HOST_MAIN;
        end
        HOST_CAL_WRITE: begin
          devAddr_reg <= ADDR_CAL_CTRL;
          devWdata_reg <= pendCal_reg;
          devWrite_reg <= 1'b1;
          calCtrl_reg <= pendCal_reg;
          state_reg <= HOST_MAIN;
        end
        HOST_MAIN: begin
          devAddr_reg <= pendAddr_reg;
          devWdata_reg <= pendData_reg;
          devWrite_reg <= 1'b1;
          if (pendAddr_reg == ADDR_LINK_EN) begin
            linkEn_reg <= pendData_reg;
          end
          if (pendAddr_reg == ADDR_CAL_CTRL) begin
            calCtrl_reg <= pendData_reg;
          end
          state_reg <= HOST_IDLE;
        end
      endcase
    end
  end

  // user reads of device addresses go out when the link path is idle; data land in readback
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      devRead_reg <= 1'b0;
      readPending_reg <= 1'b0;
      readback_reg <= '0;
      cmdRdata <= '0;
    end else if (ce) begin
      devRead_reg <= cmdRead && state_reg == HOST_IDLE && !cmdWrite &&
                     cmdAddr != ADDR_HOST_STATUS && cmdAddr != ADDR_HOST_READBACK;
      readPending_reg <= devRead_reg;
      if (readPending_reg) begin
        readback_reg <= bus.regRdata;
      end
      cmdRdata <= '0;
      if (cmdRead) begin
        if (cmdAddr == ADDR_HOST_STATUS) begin
          cmdRdata[BIT_HOST_BUSY] <= (state_reg != HOST_IDLE);
        end else if (cmdAddr == ADDR_HOST_READBACK) begin
          cmdRdata <= readback_reg;
        end
      end
    end
  end

  assign bus.regAddr = devRead_reg ? pendAddr_reg : devAddr_reg;
  assign bus.regWdata = devWdata_reg;
  assign bus.regWrite = devWrite_reg;
  assign bus.regRead = devRead_reg;
endmodule

// ===== verif/slc_monitor.sv
// assertions on the register path between the configuring end and the link control bank
// assumes one clock domain and that the configuring end makes every write on the path
`timescale 1ns/1ps
module slc_monitor
  import slc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [DATA_W-1:0] regRdata
);
  logic [DATA_W-1:0] shadowReg [7];
  logic [DATA_W-1:0] modeReg;
  logic [DATA_W-1:0] expRdReg;
  logic [2:0] slotNow;

  function automatic logic [2:0] slotOf(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_LSB_CTRL: return 3'h0;
      ADDR_LINK_EN: return 3'h1;
      ADDR_MF_LEN: return 3'h2;
      ADDR_SOFT_SYNC: return 3'h3;
      ADDR_LINK_CTRL: return 3'h4;
      ADDR_CAL_CTRL: return 3'h5;
      ADDR_MODE_MASK: return 3'h6;
      default: return 3'h7;
    endcase
  endfunction

  assign slotNow = slotOf(regAddr);

  // own copy of every plain register, so readback is judged without looking inside
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      shadowReg <= '{8'h00, 8'h01, 8'h1f, 8'h01, 8'h03, 8'h00, 8'hff};
    end else if (regWrite && slotNow != 3'h7) begin
      shadowReg[slotNow] <= regWdata;
    end
  end

  // a mode outside the table or not allowed by the mask leaves the old mode in place
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      modeReg <= 8'h02;
    end else if (regWrite && regAddr == ADDR_LINK_MODE && regWdata < 8'h08
                 && shadowReg[6][regWdata[2:0]]) begin
      modeReg <= regWdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (regAddr == ADDR_LINK_MODE) begin
      expRdReg <= modeReg;
    end else if (slotNow == 3'h7) begin
      expRdReg <= 8'h00;
    end else begin
      expRdReg <= shadowReg[slotNow];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence plainRead;
    regRead && slotNow != 3'h7;
  endsequence
  sequence modeRead;
    regRead && regAddr == ADDR_LINK_MODE;
  endsequence
  sequence deadRead;
    regRead && slotNow == 3'h7 && regAddr != ADDR_LINK_MODE && regAddr != ADDR_LINK_STATUS;
  endsequence

  AST_PLAIN_READBACK: assert property (plainRead |=> regRdata == expRdReg)
    else $error("plain register readback differs from last write");
  AST_MODE_READBACK: assert property (modeRead |=> regRdata == expRdReg)
    else $error("mode readback differs from last accepted mode");
  AST_UNMAPPED_ZERO: assert property (deadRead |=> regRdata == 8'h00)
    else $error("unmapped read returned nonzero");
  AST_QUIET_RDATA: assert property (!regRead |=> regRdata == 8'h00)
    else $error("read data present without a read");
  AST_ONE_STROBE: assert property (!(regWrite && regRead))
    else $error("write and read strobes together");
  AST_MODE_WHEN_IDLE: assert property (regWrite && regAddr == ADDR_LINK_MODE
    |-> !shadowReg[1][0] && !shadowReg[5][0]) else $error("mode written while link or cal on");
  AST_CAL_BEFORE_LINK: assert property (regWrite && regAddr == ADDR_LINK_EN && regWdata[0]
    |-> shadowReg[5][0]) else $error("link enabled without calibration");
  AST_LINK_BEFORE_CAL_OFF: assert property (regWrite && regAddr == ADDR_CAL_CTRL
    && !regWdata[0] |-> !shadowReg[1][0]) else $error("calibration cleared with link on");
  AST_CFG_WHEN_OFF: assert property (regWrite
    && (regAddr == ADDR_MF_LEN || regAddr == ADDR_LINK_CTRL) |-> !shadowReg[1][0])
    else $error("link configuration written with link on");
  AST_TS_NEEDS_RECV: assert property (regWrite && regAddr == ADDR_LSB_CTRL && regWdata[0]
    |-> shadowReg[5][1]) else $error("timestamp enabled without sync receiver");
endmodule

// ===== verif/serial_link_control_regs_test.sv
// self-checking bench: configuring end and link control bank joined by their register path
// assumes the configuring end clears link and calibration itself before a mode change
`timescale 1ns/1ps
module serial_link_control_regs_test;
  import slc_pkg::*;
  logic clk_sys, srst, ce, cmdWrite, cmdRead, rdPend;
  logic [ADDR_W-1:0] cmdAddr;
  logic [DATA_W-1:0] cmdWdata, cmdRdata;
  logic [SAMPLE_W-1:0] sampleIn, sampleOut, smpVal;
  logic sampleInValid, timestampPin, syncPin_n, sysrefPin, frameTick;
  logic sampleOutValid, linkReset, serializerPowerDown, linkClockEnable, syncRequest;
  logic scramblerOn, upperLaneMap, lmfcBoundary, calibrationEnable, syncReceiverEnable;
  logic [1:0] ilaControlBits;
  logic [DATA_W-1:0] rdQ [$];
  logic [SAMPLE_W-1:0] smpQ [$];
  int failures, numChecks, cycles, gap, seed;
  localparam logic [ADDR_W-1:0] RST_ADDR [8] = '{ADDR_LSB_CTRL, ADDR_LINK_EN, ADDR_LINK_MODE,
    ADDR_MF_LEN, ADDR_SOFT_SYNC, ADDR_LINK_CTRL, ADDR_CAL_CTRL, ADDR_MODE_MASK};
  localparam logic [DATA_W-1:0] RST_DATA [8] = '{8'h00, 8'h01, 8'h02, 8'h1f, 8'h01, 8'h03,
    8'h00, 8'hff};

  slc_link_if i_slc_link_if();
  slc_device i_slc_device(.clk_sys(clk_sys), .srst(srst), .ce(ce), .bus(i_slc_link_if),
    .sampleIn(sampleIn), .sampleInValid(sampleInValid), .timestampPin(timestampPin),
    .syncPin_n(syncPin_n), .sysrefPin(sysrefPin), .frameTick(frameTick),
    .sampleOut(sampleOut), .sampleOutValid(sampleOutValid), .linkReset(linkReset),
    .serializerPowerDown(serializerPowerDown), .linkClockEnable(linkClockEnable),
    .syncRequest(syncRequest), .scramblerOn(scramblerOn), .upperLaneMap(upperLaneMap),
    .lmfcBoundary(lmfcBoundary), .ilaControlBits(ilaControlBits),
    .calibrationEnable(calibrationEnable), .syncReceiverEnable(syncReceiverEnable));
  slc_host i_slc_host(.clk_sys(clk_sys), .srst(srst), .ce(ce), .bus(i_slc_link_if),
    .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
    .cmdRdata(cmdRdata));
  slc_monitor i_slc_monitor(.clk_sys(clk_sys), .srst(srst), .regAddr(i_slc_link_if.regAddr),
    .regWdata(i_slc_link_if.regWdata), .regWrite(i_slc_link_if.regWrite),
    .regRead(i_slc_link_if.regRead), .regRdata(i_slc_link_if.regRdata));

  task automatic check(input logic [SAMPLE_W-1:0] got, input logic [SAMPLE_W-1:0] exp);
    numChecks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // busy lasts at most three cycles, so six idle cycles always leave the host ready
  task automatic hostWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    cmdAddr <= a;
    cmdWdata <= d;
    cmdWrite <= 1'b1;
    @(posedge clk_sys);
    cmdWrite <= 1'b0;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic cmdRd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk_sys);
    cmdAddr <= a;
    cmdRead <= 1'b1;
    rdQ.push_back(e);
    @(posedge clk_sys);
    cmdRead <= 1'b0;
  endtask

  // a device read answers 0 on the command port; the value comes back through readback
  task automatic devRead(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    cmdRd(a, 8'h00);
    repeat (4) @(posedge clk_sys);
    cmdRd(ADDR_HOST_READBACK, e);
    @(negedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    if (rdPend === 1'b1) check(12'(cmdRdata), 12'(rdQ.pop_front()));
    rdPend <= cmdRead;
    if (sampleOutValid === 1'b1) begin
      if (smpQ.size() == 0) check(12'h001, 12'h000);
      else check(sampleOut, smpQ.pop_front());
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      wrap_up();
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    {srst, ce, cmdWrite, cmdRead, rdPend, sampleInValid} = 6'h30;
    {timestampPin, syncPin_n, sysrefPin, frameTick} = 4'h4;
    cmdAddr = 12'h000;
    cmdWdata = 8'h00;
    sampleIn = 12'h000;
    seed = 32'h04db;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) devRead(RST_ADDR[i], RST_DATA[i]);
    devRead(12'h7ff, 8'h00);
    check(12'({linkReset, linkClockEnable, scramblerOn}), 12'h003);
    check(12'(ilaControlBits), 12'h000);
    hostWrite(ADDR_LINK_MODE, 8'h03);
    devRead(ADDR_LINK_EN, 8'h00);
    devRead(ADDR_LINK_MODE, 8'h03);
    check(12'({linkReset, serializerPowerDown, linkClockEnable}), 12'h006);
    hostWrite(ADDR_LINK_MODE, 8'h09);
    devRead(ADDR_LINK_MODE, 8'h03);
    hostWrite(ADDR_MODE_MASK, 8'hfb);
    hostWrite(ADDR_LINK_MODE, 8'h02);
    devRead(ADDR_LINK_MODE, 8'h03);
    hostWrite(ADDR_LINK_MODE, 8'h01);
    devRead(ADDR_LINK_MODE, 8'h01);
    hostWrite(ADDR_CAL_CTRL, 8'h01);
    check(12'({calibrationEnable, syncReceiverEnable}), 12'h002);
    for (int i = 0; i < 4; i++) begin
      gap = $random(seed);
      hostWrite(RST_ADDR[i == 0 ? 0 : i + 2], 8'(gap));
      devRead(RST_ADDR[i == 0 ? 0 : i + 2], 8'(gap));
    end
    // source 2 so that the stuck pin below cannot hold a request; offset binary
    hostWrite(ADDR_LINK_CTRL, 8'h19);
    hostWrite(ADDR_MF_LEN, 8'h05);
    hostWrite(ADDR_SOFT_SYNC, 8'h01);
    hostWrite(ADDR_LSB_CTRL, 8'h01);
    hostWrite(ADDR_LINK_EN, 8'h01);
    check(12'({linkReset, linkClockEnable, upperLaneMap, scramblerOn}), 12'h007);
    devRead(ADDR_LINK_STATUS, 8'h00);
    @(posedge clk_sys);
    syncPin_n <= 1'b0;
    repeat (8) @(negedge clk_sys);
    check(12'(syncRequest), 12'h000);
    hostWrite(ADDR_SOFT_SYNC, 8'h00);
    check(12'(syncRequest), 12'h001);
    hostWrite(ADDR_SOFT_SYNC, 8'h01);
    check(12'(syncRequest), 12'h000);
    @(posedge clk_sys);
    syncPin_n <= 1'b1;
    frameTick <= 1'b1;
    gap = 0;
    while (lmfcBoundary !== 1'b1 && gap < 300) begin
      @(negedge clk_sys);
      gap++;
    end
    gap = 0;
    do begin
      @(negedge clk_sys);
      gap++;
    end while (lmfcBoundary !== 1'b1 && gap < 300);
    check(12'(gap), 12'h006);
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_sys);
      smpVal = 12'($random(seed));
      timestampPin <= i[2];
      sampleIn <= smpVal;
      sampleInValid <= 1'b1;
      smpQ.push_back({4'h0, ~smpVal[11], smpVal[10:5], i[2]});
    end
    @(posedge clk_sys);
    sampleInValid <= 1'b0;
    repeat (12) @(posedge clk_sys);
    check(12'(smpQ.size()), 12'h000);
    hostWrite(ADDR_LINK_EN, 8'h00);
    check(12'({linkReset, serializerPowerDown, linkClockEnable}), 12'h006);
    devRead(ADDR_LINK_STATUS, 8'h02);
    @(posedge clk_sys);
    sampleInValid <= 1'b1;
    gap = 0;
    for (int i = 0; i < 100; i++) begin
      @(negedge clk_sys);
      if (lmfcBoundary !== 1'b0) gap++;
    end
    check(12'(gap), 12'h000);
    check(12'(sampleOutValid), 12'h000);
    @(posedge clk_sys);
    sampleInValid <= 1'b0;
    hostWrite(ADDR_LINK_MODE, 8'h05);
    devRead(ADDR_CAL_CTRL, 8'h02);
    repeat (2) @(negedge clk_sys);
    wrap_up();
  end
endmodule
